// ### test/diev_field_model.sv
// Behavioural model of the conditioned field inputs and their external strobes.
`timescale 1ns/1ps
module diev_field_model
    import diev_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Field side
    output diev_pair_t       points,
    output logic [1:0]       ext_strobe
);
    int cnt  = 0;
    int last = -100000;

    // Free cycle count, used to keep strobe rises far enough apart.
    always @(posedge clk_sys) cnt <= cnt + 1;

    // Quiet fields and strobes from time zero.
    initial begin
        points     = '0;
        ext_strobe = 2'h0;
    end

    // Levels change just after an edge, as the conditioners deliver them.
    task automatic set_field(input int f, input logic [15:0] v);
        @(posedge clk_sys);
        points[f] <= v;
    endtask

    // A pulse of 1 us; a faster strobe would not be honoured, so we wait.
    task automatic strobe(input int f);
        while (cnt - last < 3200) @(posedge clk_sys);
        @(posedge clk_sys);
        ext_strobe[f] <= 1'b1;
        last          <= cnt;
        repeat (200) @(posedge clk_sys);
        ext_strobe[f] <= 1'b0;
    endtask
endmodule

// ### test/testbench.sv
// Self-checking testbench of the digital input event detector.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module testbench
    import diev_pkg::*;
();
    // One internal strobe period of 3200 cycles plus margin.
    localparam int GAP = 3300;
    logic        clk_sys;
    logic        arst_n;
    diev_req_t   req;
    logic [15:0] reg_rdata;
    diev_pair_t  points;
    logic [1:0]  ext_strobe;
    logic        irq_local;
    logic        irq_host;
    int          n_errors = 0;
    int          n_checks = 0;
    logic [15:0] v;
    logic [15:0] e;
    logic [31:0] pv;
    logic [4:0]  rw_a [4];

    // ****************************************
    // Device and field model
    // ****************************************
    diev_top i_diev_top (.clk_sys(clk_sys), .arst_n(arst_n), .req(req), .reg_rdata(reg_rdata),
        .points(points), .ext_strobe(ext_strobe), .irq_local(irq_local), .irq_host(irq_host));
    diev_field_model i_diev_field_model (.clk_sys(clk_sys), .points(points),
        .ext_strobe(ext_strobe));

    // ****************************************
    // Helpers
    // ****************************************
    // 200 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the read edge, so sample there.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic chk_rd(input logic [4:0] a, input logic [15:0] x);
        logic [15:0] d;
        rd(a, d);
        `CHK(d, x)
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Expected events between two samples, worked out per point.
    function automatic logic [15:0] ev(input logic [15:0] p, n, u, s, a);
        return u & ((a & (p ^ n)) | (~a & s & ~p & n) | (~a & ~s & p & ~n));
    endfunction

    task automatic end_sim;
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog: the tests take about 17000 cycles.
    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        end_sim;
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        req    = '0;
        arst_n = 1'b0;
        rw_a   = '{A_UNMSK1, A_SENSE1, A_ANYE1, A_IEN1};
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        chk_rd(A_CTRL, 16'h0000);
        chk_rd(A_FLAG0, 16'h0000);
        chk_rd(5'h1F, 16'h0000);
        `CHK(irq_local, 1'b0)
        // Settings read back, then go back to masked.
        foreach (rw_a[i]) begin
            wr(rw_a[i], 16'hC35A + 16'(i));
            chk_rd(rw_a[i], 16'hC35A + 16'(i));
            wr(rw_a[i], 16'h0000);
        end
        // Internal sampling, whole fields, points and field sequence.
        i_diev_field_model.set_field(0, 16'hA5C3);
        i_diev_field_model.set_field(1, 16'h1235);
        cyc(GAP);
        chk_rd(A_FIELD0, 16'hA5C3);
        chk_rd(A_FIELD1, 16'h1235);
        wr(A_FIELD0, 16'hFFFF);
        chk_rd(A_FIELD0, 16'hA5C3);
        pv = 32'h1235A5C3;
        wr(A_POINT, 16'h000F);
        for (int i = 15; i < 19; i++) begin
            rd(A_POINT, v);
            `CHK(v, 16'(pv[i]))
        end
        wr(A_FSEQ, 16'h0000);
        chk_rd(A_FSEQ, 16'hA5C3);
        chk_rd(A_FSEQ, 16'h1235);
        // Events: masked, rising, falling and any-edge points in one step.
        wr(A_UNMSK0, 16'h7E7E);
        wr(A_SENSE0, 16'h0FF0);
        wr(A_ANYE0, 16'h0303);
        wr(A_IEN0, 16'hFFFF);
        // Field 1: point 5 fires on any edge, point 0 on a falling edge.
        wr(A_UNMSK1, 16'h0021);
        wr(A_ANYE1, 16'h0020);
        wr(A_CTRL, 16'h0001);
        wr(A_CLR0, 16'hFFFF);
        e = ev(16'hA5C3, 16'h5A3C, 16'h7E7E, 16'h0FF0, 16'h0303);
        i_diev_field_model.set_field(0, 16'h5A3C);
        i_diev_field_model.set_field(1, 16'h1214);
        cyc(GAP);
        chk_rd(A_FLAG0, e);
        chk_rd(A_FLAG1, ev(16'h1235, 16'h1214, 16'h0021, 16'h0000, 16'h0020));
        `CHK(irq_local, 1'b1)
        `CHK(irq_host, 1'b0)
        cyc(GAP);
        chk_rd(A_FLAG0, e);
        chk_rd(A_FLAG1, 16'h0021);
        `CHK(irq_local, 1'b1)
        wr(A_CTRL, 16'h0005);
        cyc(3);
        `CHK({irq_host, irq_local}, 2'b10)
        wr(A_IEN0, ~e);
        cyc(3);
        `CHK(irq_host, 1'b0)
        wr(A_IEN0, 16'hFFFF);
        wr(A_CTRL, 16'h0004);
        cyc(3);
        `CHK(irq_host, 1'b0)
        wr(A_CLR0, e);
        chk_rd(A_FLAG0, 16'h0000);
        wr(A_CLR1, 16'h0021);
        chk_rd(A_FLAG1, 16'h0000);
        // External strobe: no internal capture, then capture 2 to 18 us later.
        wr(A_CTRL, 16'h0008);
        i_diev_field_model.set_field(0, 16'h0F0F);
        cyc(GAP);
        chk_rd(A_FIELD0, 16'h5A3C);
        fork
            i_diev_field_model.strobe(0);
        join_none
        // The strobe edge is seen two edges in; the read below lands just before 2 us.
        cyc(390);
        chk_rd(A_FIELD0, 16'h5A3C);
        // This read lands a few cycles before the 18 us limit.
        cyc(3200);
        chk_rd(A_FIELD0, 16'h0F0F);
        end_sim;
    end
endmodule

// ### verilog/diev_pkg.sv
// Constants, register map and types of the digital input event detector.
// Operation
// [R01] 32 inputs form two 16-bit fields; read a whole field or one point.
// [R02] Field reads may return one field or walk through consecutive fields.
// [R03] Point reads may return one point or walk through consecutive points.
// [R04] A qualifying event on any of the 32 points raises the interrupt.
// [R05] Events latch in two 16-bit flag registers, one bit per point.
// [R06] A masked point never sets its flag nor causes an interrupt.
// [R07] Per-point sense picks rising or falling transition as the event.
// [R08] Per-point any-edge override makes every transition an event.
// [R09] Interrupt enable per point or per field; route to local or host.
// [R10] Each field has an external strobe that replaces internal sampling.
// [R11] Capture follows an external strobe edge by 2 to 18 us.
// [R12] The outside party keeps external strobes at or below 62.5 kHz.
// [R13] An external strobe pulse of 1 us is detected.
// [R14] Internal strobe sampling catches any level lasting at least 16 us.
// [R15] A field read completes within 42 us.
// [R16] Flags stay set until cleared; interrupt holds while an enabled flag is set.
package diev_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ      = 200;
    localparam int MIN_LEVEL_US = 16;
    localparam int CAP_MIN_US   = 2;
    localparam int CAP_MAX_US   = 18;
    // The internal strobe period equals the shortest level that must be seen.
    localparam int INT_CYC      = MIN_LEVEL_US * CLK_MHZ;
    localparam int CAP_MIN_CYC  = CAP_MIN_US * CLK_MHZ;
    localparam int CAP_MAX_CYC  = CAP_MAX_US * CLK_MHZ;
    localparam logic [11:0] INT_LAST = 12'(INT_CYC - 1);
    localparam logic [11:0] CAP_LAST = 12'(CAP_MIN_CYC - 1);

    // ****************************************
    // Register map (word addresses)
    // ****************************************
    localparam logic [4:0] A_FIELD0 = 5'h00;
    localparam logic [4:0] A_FIELD1 = 5'h01;
    localparam logic [4:0] A_UNMSK0 = 5'h02;
    localparam logic [4:0] A_UNMSK1 = 5'h03;
    localparam logic [4:0] A_SENSE0 = 5'h04;
    localparam logic [4:0] A_SENSE1 = 5'h05;
    localparam logic [4:0] A_ANYE0  = 5'h06;
    localparam logic [4:0] A_ANYE1  = 5'h07;
    localparam logic [4:0] A_FLAG0  = 5'h08;
    localparam logic [4:0] A_FLAG1  = 5'h09;
    localparam logic [4:0] A_CLR0   = 5'h0A;
    localparam logic [4:0] A_CLR1   = 5'h0B;
    localparam logic [4:0] A_IEN0   = 5'h0C;
    localparam logic [4:0] A_IEN1   = 5'h0D;
    localparam logic [4:0] A_CTRL   = 5'h0E;
    localparam logic [4:0] A_POINT  = 5'h0F;
    localparam logic [4:0] A_FSEQ   = 5'h10;

    // Control register fields.
    localparam int CTRL_FEN0  = 0;
    localparam int CTRL_FEN1  = 1;
    localparam int CTRL_HOST  = 2;
    localparam int CTRL_EXT0  = 3;
    localparam int CTRL_EXT1  = 4;
    localparam logic [4:0] CTRL_RST  = 5'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [1:0][15:0] diev_pair_t;

    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } diev_req_t;

    typedef struct packed {
        diev_pair_t       data;
        diev_pair_t       unmask;
        diev_pair_t       sense;
        diev_pair_t       anye;
        diev_pair_t       flag;
        diev_pair_t       ien;
        logic [4:0]       ctrl;
        logic [4:0]       pidx;
        logic             fidx;
        logic [11:0]      tick;
        logic [1:0]       stb_prev;
        logic [1:0]       pend;
        logic [1:0][11:0] dly;
        logic [15:0]      rdata;
        logic             irq_loc;
        logic             irq_host;
    } diev_state_t;

endpackage

// ### verilog/diev_top.sv
// Digital input event detector: sampling, event flags, interrupt and registers.
`timescale 1ns/1ps
module diev_top
    import diev_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // Register port
    input  wire diev_req_t   req,
    output logic [15:0]      reg_rdata,
    // Field inputs from the conditioning modules
    input  wire diev_pair_t  points,
    input  wire logic [1:0]  ext_strobe,
    // Interrupts
    output logic             irq_local,
    output logic             irq_host
);

    diev_state_t st_r;
    diev_state_t st_nxt;

    // ****************************************
    // Event qualification
    // ****************************************

    // One field's qualified events between the old and the new sample.
    function automatic logic [15:0] ev_calc(
        input logic [15:0] prev,
        input logic [15:0] cur,
        input logic [15:0] unm,
        input logic [15:0] sen,
        input logic [15:0] any
    );
        logic [15:0] rise;
        logic [15:0] fall;
        rise = cur & ~prev;
        fall = prev & ~cur;
        // Override wins over the sense choice; the unmask gates all of it.
        return unm & ((any & (rise | fall))                 // see [R08]
                   | (~any & ((sen & rise) | (~sen & fall)))); // see [R07] see [R06]
    endfunction

    // ****************************************
    // Next-state logic
    // ****************************************

    // All state moves through one copy so reads, writes and sampling stay aligned.
    always_comb begin
        logic        int_tick;
        logic        sample;
        logic        stb_edge;
        logic [15:0] clr;
        logic [15:0] ev;
        logic        pend_any;
        int_tick = 1'b0;
        sample   = 1'b0;
        stb_edge = 1'b0;
        clr      = 16'h0000;
        ev       = 16'h0000;
        pend_any = 1'b0;
        st_nxt   = st_r;
        st_nxt.rdata = 16'h0000;

        // Internal strobe, free running.
        if (st_r.tick == INT_LAST) begin
            st_nxt.tick = 12'h000;
            int_tick    = 1'b1;
        end else begin
            st_nxt.tick = st_r.tick + 12'h001;
        end

        for (int f = 0; f < 2; f++) begin
            sample   = 1'b0;
            // Every cycle is looked at, so a 1 us pulse cannot slip by.
            stb_edge = ext_strobe[f] & ~st_r.stb_prev[f];     // see [R13]
            st_nxt.stb_prev[f] = ext_strobe[f];
            if (st_r.ctrl[CTRL_EXT0 + f]) begin              // see [R10]
                // Edges during a pending capture are dropped; the far end
                // keeps its strobe rate low enough for this.   see [R12]
                if (st_r.pend[f]) begin
                    if (st_r.dly[f] == CAP_LAST) begin       // see [R11]
                        sample           = 1'b1;
                        st_nxt.pend[f]   = 1'b0;
                    end else begin
                        st_nxt.dly[f] = st_r.dly[f] + 12'h001;
                    end
                end else if (stb_edge) begin
                    st_nxt.pend[f] = 1'b1;
                    st_nxt.dly[f]  = 12'h000;
                end
            end else begin
                st_nxt.pend[f] = 1'b0;
                sample         = int_tick;                   // see [R14]
            end

            ev = 16'h0000;
            if (sample) begin
                st_nxt.data[f] = points[f];
                ev = ev_calc(st_r.data[f], points[f], st_r.unmask[f],
                             st_r.sense[f], st_r.anye[f]);
            end

            clr = 16'h0000;
            if (req.wr && req.addr == (f == 0 ? A_CLR0 : A_CLR1)) begin
                clr = req.wdata;
            end
            // A new event wins over a clear in the same cycle.
            st_nxt.flag[f] = (st_r.flag[f] & ~clr) | ev;     // see [R05] see [R16]
        end

        // Register writes.
        if (req.wr) begin
            unique case (req.addr)
                A_UNMSK0: st_nxt.unmask[0] = req.wdata;
                A_UNMSK1: st_nxt.unmask[1] = req.wdata;
                A_SENSE0: st_nxt.sense[0]  = req.wdata;
                A_SENSE1: st_nxt.sense[1]  = req.wdata;
                A_ANYE0:  st_nxt.anye[0]   = req.wdata;
                A_ANYE1:  st_nxt.anye[1]   = req.wdata;
                A_IEN0:   st_nxt.ien[0]    = req.wdata;
                A_IEN1:   st_nxt.ien[1]    = req.wdata;
                A_CTRL:   st_nxt.ctrl      = req.wdata[4:0];
                A_POINT:  st_nxt.pidx      = req.wdata[4:0];
                A_FSEQ:   st_nxt.fidx      = req.wdata[0];
                default:  ;
            endcase
        end

        // Register reads; the word stands one cycle, then returns to zero.
        if (req.rd) begin
            unique case (req.addr)
                A_FIELD0: st_nxt.rdata = st_r.data[0];       // see [R01] see [R15]
                A_FIELD1: st_nxt.rdata = st_r.data[1];
                A_UNMSK0: st_nxt.rdata = st_r.unmask[0];
                A_UNMSK1: st_nxt.rdata = st_r.unmask[1];
                A_SENSE0: st_nxt.rdata = st_r.sense[0];
                A_SENSE1: st_nxt.rdata = st_r.sense[1];
                A_ANYE0:  st_nxt.rdata = st_r.anye[0];
                A_ANYE1:  st_nxt.rdata = st_r.anye[1];
                A_FLAG0:  st_nxt.rdata = st_r.flag[0];
                A_FLAG1:  st_nxt.rdata = st_r.flag[1];
                A_IEN0:   st_nxt.rdata = st_r.ien[0];
                A_IEN1:   st_nxt.rdata = st_r.ien[1];
                A_CTRL:   st_nxt.rdata = {11'h000, st_r.ctrl};
                A_POINT: begin
                    // Each read steps to the next point, wrapping at 32.
                    st_nxt.rdata = {15'h0000, st_r.data[st_r.pidx[4]][st_r.pidx[3:0]]};
                    st_nxt.pidx  = st_r.pidx + 5'h01;        // see [R03] see [R01]
                end
                A_FSEQ: begin
                    st_nxt.rdata = st_r.data[st_r.fidx];
                    st_nxt.fidx  = ~st_r.fidx;               // see [R02]
                end
                default:  st_nxt.rdata = 16'h0000;
            endcase
        end

        // Field enable and point enable both gate the pending flags.
        pend_any = |(st_r.flag[0] & st_r.ien[0] & {16{st_r.ctrl[CTRL_FEN0]}})
                 | |(st_r.flag[1] & st_r.ien[1] & {16{st_r.ctrl[CTRL_FEN1]}}); // see [R09]
        st_nxt.irq_loc  = pend_any & ~st_r.ctrl[CTRL_HOST]; // see [R04]
        st_nxt.irq_host = pend_any & st_r.ctrl[CTRL_HOST];
    end

    // ****************************************
    // State register
    // ****************************************

    // Every field resets to a constant; masks clear so nothing fires early.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata = st_r.rdata;
    assign irq_local = st_r.irq_loc;
    assign irq_host  = st_r.irq_host;

    // ****************************************
    // Assertions
    // ****************************************

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    // Helper counters for the timing checks. A delay range of thousands of cycles
    // unrolls into as many threads, so the cycles are counted here instead.
    logic [12:0] cap_age_r;
    logic [12:0] tick_age_r;

    // Age of a pending field 0 capture, and cycles since the internal strobe fired.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cap_age_r  <= 13'h0000;
            tick_age_r <= 13'h0000;
        end else begin
            if (st_r.ctrl[CTRL_EXT0] && !st_r.pend[0] && ext_strobe[0] && !st_r.stb_prev[0]) begin
                cap_age_r <= 13'h0001;
            end else if (st_r.pend[0]) begin
                cap_age_r <= cap_age_r + 13'h0001;
            end else begin
                cap_age_r <= 13'h0000;
            end
            if (st_r.tick == INT_LAST) begin
                tick_age_r <= 13'h0000;
            end else begin
                tick_age_r <= tick_age_r + 13'h0001;
            end
        end
    end

    sequence s_ext_edge0;
        st_r.ctrl[CTRL_EXT0] && !st_r.pend[0] && ext_strobe[0] && !st_r.stb_prev[0];
    endsequence

    // A pending capture ends by sampling, not by leaving external mode.
    sequence s_ext_capture0;
        $fell(st_r.pend[0]) && $past(st_r.ctrl[CTRL_EXT0]);
    endsequence

    a_ext_arm: assert property ( // see [R13]
        s_ext_edge0 |=> st_r.pend[0] && cap_age_r == 13'h0001)
        else $error("strobe edge did not arm capture");

    a_ext_delay: assert property ( // see [R11]
        s_ext_capture0 |-> cap_age_r >= 13'(CAP_MIN_CYC + 1) && cap_age_r <= 13'(CAP_MAX_CYC + 1))
        else $error("external capture outside 2..18 us");

    a_ext_bound: assert property (cap_age_r <= 13'(CAP_MAX_CYC + 1)) // see [R11]
        else $error("external capture overdue");

    a_masked_quiet: assert property ( // see [R06]
        ((st_r.flag[0] & ~$past(st_r.flag[0]) & ~$past(st_r.unmask[0])) == 16'h0000))
        else $error("masked point set its flag");

    a_flag_sticky: assert property ( // see [R16]
        (st_r.flag[1][0] && !(req.wr && req.addr == A_CLR1 && req.wdata[0]))
        |=> st_r.flag[1][0])
        else $error("flag dropped without clear");

    a_flag_clear: assert property ( // see [R05]
        (req.wr && req.addr == A_CLR0 && req.wdata == 16'hFFFF && st_r.tick != INT_LAST
         && !st_r.ctrl[CTRL_EXT0]) |=> st_r.flag[0] == 16'h0000)
        else $error("clear did not empty flags");

    a_irq_level: assert property ( // see [R04]
        (|(st_r.flag[0] & st_r.ien[0]) && st_r.ctrl[CTRL_FEN0] && !st_r.ctrl[CTRL_HOST]
         && $stable(st_r.ctrl)) |=> irq_local && !irq_host)
        else $error("local interrupt missing");

    a_int_period: assert property ( // see [R14]
        (st_r.tick == INT_LAST) |-> tick_age_r == 13'(INT_CYC - 1))
        else $error("internal strobe period wrong");

    a_int_bound: assert property (tick_age_r < 13'(INT_CYC)) // see [R14]
        else $error("internal strobe overdue");

    a_field_read: assert property ( // see [R01]
        (req.rd && req.addr == A_FIELD1) |=> reg_rdata == $past(st_r.data[1]) ##1
        (reg_rdata == 16'h0000 || $past(req.rd)))
        else $error("field read data wrong");

    a_point_step: assert property ( // see [R03]
        (req.rd && req.addr == A_POINT && !req.wr) |=> st_r.pidx == $past(st_r.pidx) + 5'h01)
        else $error("point index did not step");

    a_any_edge: assert property ( // see [R08]
        (st_r.tick == INT_LAST && !st_r.ctrl[CTRL_EXT1] && st_r.unmask[1][5]
         && st_r.anye[1][5] && points[1][5] != st_r.data[1][5]) |=> st_r.flag[1][5])
        else $error("override edge not flagged");

endmodule
